// ===== rtl/supply_supervisor_pkg.sv
// Purpose: Shared constants for the logic supply supervisor
// Assumes: 250 MHz reference clock
// Notes: Times in their own unit, cycle counts derived from them

package supply_supervisor_pkg;

	// ----------------------------------------
	// Clock
	// ----------------------------------------
	localparam int CLK_MHZ = 250;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int POR_DELAY_NS = 220000;
	localparam int POR_DELAY_MAX_NS = 500000;
	localparam int POR_CYCLES = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int FIL_TIME_MIN_US = 60;
	localparam int FIL_TIME_US = 100;
	localparam int FIL_TIME_MAX_US = 135;
	localparam int FIL_CYCLES = FIL_TIME_US * CLK_MHZ;
	localparam int FIL_CNT_W = 15;
	localparam int POR_CNT_W = 17;

	// ----------------------------------------
	// Supply status/control layout
	// ----------------------------------------
	localparam int STAT_W = 8;
	localparam int STAT_OV_OK_BIT = 0;
	localparam int STAT_UV_OK_BIT = 1;
	localparam int STAT_MON_OK_BIT = 2;
	localparam int STAT_LATCH_BIT = 3;
	localparam int STAT_TEST_LO_BIT = 6;
	localparam int STAT_TEST_HI_BIT = 7;
	localparam logic [1:0] TEST_OV_CODE = 2'h0;
	localparam logic [1:0] TEST_UV_CODE = 2'h1;
	localparam logic LATCH_SEL_RESET = 1'h0;
	localparam logic [STAT_W-1:0] STAT_RESET = 8'h00;

endpackage

// ===== rtl/supply_glitch_filter.sv
// Purpose: Glitch filter for one supply monitor decision
// Assumes: Raw input synchronous to the clock
// Notes: Output follows the input only after it held steady long enough

`timescale 1ns/100ps

module supply_glitch_filter #(
	parameter logic [supply_supervisor_pkg::FIL_CNT_W-1:0] SET_CYCLES = 15'h61A8,
	parameter logic [supply_supervisor_pkg::FIL_CNT_W-1:0] CLR_CYCLES = 15'h61A8
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Control
	input wire logic i_clear,
	// Decision
	input wire logic i_raw,
	output logic o_level
);

	typedef struct packed {
		logic level;
		logic [supply_supervisor_pkg::FIL_CNT_W-1:0] cnt;
	} filt_state_t;

	filt_state_t s_q;
	filt_state_t s_d;
	logic [supply_supervisor_pkg::FIL_CNT_W-1:0] limit;

	always_comb begin
		s_d = s_q;
		limit = s_q.level ? CLR_CYCLES : SET_CYCLES;
		if (i_clear) begin
			s_d.level = 1'b0;
			s_d.cnt = '0;
		end else if (i_raw == s_q.level) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= limit - 15'h0001) begin
			s_d.level = i_raw;
			s_d.cnt = '0;
		end else begin
			s_d.cnt = s_q.cnt + 15'h0001;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_level = s_q.level;

endmodule // supply_glitch_filter

// ===== rtl/logic_supply_supervisor.sv
// Purpose: Logic supply supervisor for an H-bridge driver
// Assumes: Supply comparators arrive as digital levels synchronous to the clock
// Notes: Bridge enable line is open drain, driven low only

`timescale 1ns/100ps

module logic_supply_supervisor #(
	parameter logic [supply_supervisor_pkg::POR_CNT_W-1:0] POR_CYCLES =
		supply_supervisor_pkg::POR_CNT_W'(supply_supervisor_pkg::POR_CYCLES),
	parameter logic [supply_supervisor_pkg::FIL_CNT_W-1:0] OFF_FILTER_CYCLES =
		supply_supervisor_pkg::FIL_CNT_W'(supply_supervisor_pkg::FIL_CYCLES),
	parameter logic [supply_supervisor_pkg::FIL_CNT_W-1:0] ON_FILTER_CYCLES =
		supply_supervisor_pkg::FIL_CNT_W'(supply_supervisor_pkg::FIL_CYCLES)
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Logic supply comparators
	input wire logic i_above_functional_reset_level,
	input wire logic i_above_por_level,
	input wire logic i_below_uv_threshold,
	input wire logic i_above_ov_threshold,
	input wire logic i_below_uv_test_threshold,
	input wire logic i_above_ov_test_threshold,
	// I/O supply mode comparator
	input wire logic i_io_supply_low,
	// Bridge enable line, open drain
	input wire logic i_bridge_enable_line,
	output logic o_bridge_enable_line,
	output logic o_bridge_enable_line_oe,
	// Output stage control
	input wire logic i_stage_on_request,
	output logic o_stage_enable,
	// Supply status/control access from serial interface
	input wire logic i_status_write,
	input wire logic [supply_supervisor_pkg::STAT_W-1:0] i_status_wdata,
	output logic [supply_supervisor_pkg::STAT_W-1:0] o_status_rdata,
	// Device wide status
	output logic o_regs_clear,
	output logic o_diag_store_enable,
	output logic o_flag_diag_mode,
	output logic o_spi_enable,
	output logic o_supply_fault_flag
);

	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_FUNC_RESET,
		ST_POR_WAIT,
		ST_RUN
	} sup_state_t;

	typedef struct packed {
		sup_state_t state;
		logic [supply_supervisor_pkg::POR_CNT_W-1:0] por_cnt;
		logic test_ov;
		logic test_uv;
		logic ov_latch_select;
		logic ov_latched;
		logic [supply_supervisor_pkg::STAT_W-1:0] rdata;
	} sup_t;

	sup_t s_q;
	sup_t s_d;

	logic uv_raw;
	logic ov_raw;
	logic uv_flt;
	logic ov_flt;
	logic filt_clear;
	logic flag_mode;
	logic running;
	logic mon_fault;
	logic supply_fault;
	logic stat_ov_ok;
	logic stat_uv_ok;
	logic stat_mon_ok;

	// ----------------------------------------
	// Mode selection
	// ----------------------------------------
	assign flag_mode = i_io_supply_low;

	// ----------------------------------------
	// Comparator selection and filtering
	// ----------------------------------------
	// Test bits move the thresholds inward so the monitor trips at nominal supply
	assign ov_raw = s_q.test_ov ? i_above_ov_test_threshold : i_above_ov_threshold;
	assign uv_raw = s_q.test_uv ? i_below_uv_test_threshold : i_below_uv_threshold;
	assign filt_clear = ~i_above_por_level;

	supply_glitch_filter #(
		.SET_CYCLES(OFF_FILTER_CYCLES),
		.CLR_CYCLES(ON_FILTER_CYCLES)
	) u_uv_filter (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_clear(filt_clear),
		.i_raw(uv_raw),
		.o_level(uv_flt)
	);

	supply_glitch_filter #(
		.SET_CYCLES(OFF_FILTER_CYCLES),
		.CLR_CYCLES(ON_FILTER_CYCLES)
	) u_ov_filter (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_clear(filt_clear),
		.i_raw(ov_raw),
		.o_level(ov_flt)
	);

	// ----------------------------------------
	// Fault decision
	// ----------------------------------------
	assign running = (s_q.state == ST_RUN) && i_above_por_level;
	assign mon_fault = uv_flt | ov_flt | s_q.ov_latched;
	assign supply_fault = ~running | mon_fault;

	assign stat_ov_ok = ~ov_flt & ~s_q.ov_latched;
	assign stat_uv_ok = ~uv_flt;
	assign stat_mon_ok = ~mon_fault;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;

		unique case (s_q.state)
			ST_FUNC_RESET: begin
				s_d.por_cnt = '0;
				if (i_above_functional_reset_level && i_above_por_level) begin
					s_d.state = ST_POR_WAIT;
				end
			end
			ST_POR_WAIT: begin
				if (!i_above_por_level) begin
					s_d.state = ST_FUNC_RESET;
					s_d.por_cnt = '0;
				end else if (s_q.por_cnt >= POR_CYCLES - 17'h00001) begin
					s_d.state = ST_RUN;
					s_d.por_cnt = '0;
				end else begin
					s_d.por_cnt = s_q.por_cnt + 17'h00001;
				end
			end
			ST_RUN: begin
				if (!i_above_por_level) begin
					s_d.state = ST_FUNC_RESET;
				end
			end
		endcase

		if (s_q.state != ST_RUN) begin
			// Registers held at default until the power-on delay ends
			s_d.test_ov = 1'b0;
			s_d.test_uv = 1'b0;
			s_d.ov_latch_select = supply_supervisor_pkg::LATCH_SEL_RESET;
			s_d.ov_latched = 1'b0;
		end else if (flag_mode) begin
			// Serial interface inactive, tests and latch unavailable
			s_d.test_ov = 1'b0;
			s_d.test_uv = 1'b0;
			s_d.ov_latched = 1'b0;
		end else begin
			// Writes taken in fault too; this register is not cleared by the line
			if (i_status_write) begin
				if (!i_status_wdata[supply_supervisor_pkg::STAT_TEST_HI_BIT]) begin
					s_d.test_ov = (i_status_wdata[supply_supervisor_pkg::STAT_TEST_HI_BIT:
						supply_supervisor_pkg::STAT_TEST_LO_BIT] == supply_supervisor_pkg::TEST_OV_CODE);
					s_d.test_uv = (i_status_wdata[supply_supervisor_pkg::STAT_TEST_HI_BIT:
						supply_supervisor_pkg::STAT_TEST_LO_BIT] == supply_supervisor_pkg::TEST_UV_CODE);
				end else begin
					s_d.test_ov = 1'b0;
					s_d.test_uv = 1'b0;
				end
				s_d.ov_latch_select = i_status_wdata[supply_supervisor_pkg::STAT_LATCH_BIT];
				if (i_status_wdata[supply_supervisor_pkg::STAT_LATCH_BIT] != s_q.ov_latch_select) begin
					s_d.ov_latched = 1'b0;
				end
			end
			// Set wins over the release by rewrite
			if (ov_flt && s_q.ov_latch_select) begin
				s_d.ov_latched = 1'b1;
			end
			if (!s_q.ov_latch_select && !(i_status_write &&
				i_status_wdata[supply_supervisor_pkg::STAT_LATCH_BIT])) begin
				s_d.ov_latched = 1'b0;
			end
		end

		// Status read back; detailed view only in SPI mode
		s_d.rdata = supply_supervisor_pkg::STAT_RESET;
		if (!flag_mode) begin
			s_d.rdata[supply_supervisor_pkg::STAT_OV_OK_BIT] = stat_ov_ok;
			s_d.rdata[supply_supervisor_pkg::STAT_UV_OK_BIT] = stat_uv_ok;
			s_d.rdata[supply_supervisor_pkg::STAT_MON_OK_BIT] = stat_mon_ok;
			s_d.rdata[supply_supervisor_pkg::STAT_LATCH_BIT] = s_d.ov_latch_select;
			s_d.rdata[supply_supervisor_pkg::STAT_TEST_HI_BIT] = ~(s_d.test_ov | s_d.test_uv);
			s_d.rdata[supply_supervisor_pkg::STAT_TEST_LO_BIT] = s_d.test_uv;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			s_q.state <= ST_FUNC_RESET;
			s_q.por_cnt <= '0;
			s_q.test_ov <= 1'b0;
			s_q.test_uv <= 1'b0;
			s_q.ov_latch_select <= supply_supervisor_pkg::LATCH_SEL_RESET;
			s_q.ov_latched <= 1'b0;
			s_q.rdata <= supply_supervisor_pkg::STAT_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Line released as soon as the fault clears, not waiting on the host
	assign o_bridge_enable_line = 1'b0;
	assign o_bridge_enable_line_oe = supply_fault;

	// Stage gated by the sensed line level and independently by the fault
	assign o_stage_enable = i_stage_on_request & i_bridge_enable_line & ~supply_fault;

	assign o_regs_clear = (s_q.state != ST_RUN);
	assign o_diag_store_enable = ~supply_fault;
	assign o_flag_diag_mode = flag_mode;
	assign o_spi_enable = ~flag_mode;
	assign o_supply_fault_flag = mon_fault;
	assign o_status_rdata = s_q.rdata;

endmodule // logic_supply_supervisor

// ===== verif/supply_supervisor_checker.sv
// Purpose: Port-level checks for the supply supervisor
// Assumes: One clock, asynchronous active-high reset
// Notes: Hold counters measure how long inputs stayed put
`timescale 1ns/100ps
module supply_supervisor_checker #(
	parameter int POR_CYCLES = 20,
	parameter int OFF_FILTER_CYCLES = 8,
	parameter int ON_FILTER_CYCLES = 8
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Watched inputs
	input wire logic i_above_functional_reset_level,
	input wire logic i_above_por_level,
	input wire logic i_below_uv_threshold,
	input wire logic i_above_ov_threshold,
	input wire logic i_below_uv_test_threshold,
	input wire logic i_above_ov_test_threshold,
	input wire logic i_io_supply_low,
	input wire logic i_bridge_enable_line,
	input wire logic i_stage_on_request,
	// Watched outputs
	input wire logic o_bridge_enable_line,
	input wire logic o_bridge_enable_line_oe,
	input wire logic o_stage_enable,
	input wire logic [supply_supervisor_pkg::STAT_W-1:0] o_status_rdata,
	input wire logic o_regs_clear,
	input wire logic o_flag_diag_mode,
	input wire logic o_spi_enable,
	input wire logic o_supply_fault_flag
);
	// ----------------------------------------
	// Hold counters
	// ----------------------------------------
	int pc;
	int bc;
	int gc;
	logic raw;
	assign raw = i_below_uv_threshold | i_above_ov_threshold | i_below_uv_test_threshold | i_above_ov_test_threshold;
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			pc <= 0;
			bc <= 0;
			gc <= 0;
		end else begin
			pc <= (i_above_por_level && i_above_functional_reset_level) ? pc + 1 : 0;
			bc <= (raw && i_above_por_level) ? bc + 1 : 0;
			gc <= raw ? 0 : gc + 1;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);
	a_por_off: assert property (!i_above_por_level |-> o_bridge_enable_line_oe && !o_stage_enable)
		else $error("stages not off below por level");
	a_stage_gate: assert property (o_stage_enable |-> i_stage_on_request && i_bridge_enable_line
		&& !o_supply_fault_flag && !o_regs_clear)
		else $error("stage on without all enables");
	a_fault_oe: assert property (o_supply_fault_flag |-> o_bridge_enable_line_oe)
		else $error("fault without line pulled low");
	a_line_low_drive: assert property (o_bridge_enable_line_oe |-> o_bridge_enable_line == 1'b0)
		else $error("line driven high");
	a_run_release: assert property (!o_supply_fault_flag && !o_regs_clear && i_above_por_level
		|-> !o_bridge_enable_line_oe)
		else $error("line held low without fault");
	a_mode_sel: assert property (o_flag_diag_mode == i_io_supply_low && o_spi_enable != i_io_supply_low)
		else $error("diagnostic mode mismatch");
	a_flag_status: assert property (i_io_supply_low && $past(i_io_supply_low) |-> o_status_rdata == 8'h00)
		else $error("status visible in flag mode");
	a_por_delay: assert property ($fell(o_regs_clear) |-> pc >= POR_CYCLES && pc <= POR_CYCLES + 1)
		else $error("por delay length wrong");
	a_flt_set: assert property ($rose(o_supply_fault_flag) |-> bc >= OFF_FILTER_CYCLES - 1)
		else $error("fault set before filter time");
	a_flt_clr: assert property ($fell(o_supply_fault_flag) && i_above_por_level
		|-> gc >= ON_FILTER_CYCLES - 2)
		else $error("fault cleared before filter time");
endmodule // supply_supervisor_checker
bind logic_supply_supervisor supply_supervisor_checker #(.POR_CYCLES(POR_CYCLES),
	.OFF_FILTER_CYCLES(OFF_FILTER_CYCLES), .ON_FILTER_CYCLES(ON_FILTER_CYCLES)) u_chk (.*);

// ===== verif/bridge_line_host.sv
// Purpose: Host side of the bridge enable wire
// Assumes: Wire has a pull-up; either party may pull it low
// Notes: A short to supply overrides every pull-down
`timescale 1ns/100ps
module bridge_line_host (
	// Device side
	input wire logic i_dev_oe,
	// Host controls
	input wire logic i_pull_low,
	input wire logic i_short_high,
	// Wire level
	output logic o_line
);
	assign o_line = i_short_high | ~(i_dev_oe | i_pull_low);
endmodule // bridge_line_host

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the supply supervisor
// Assumes: Shortened POR and filter counts
// Notes: Stimulus on rising edge, checks on falling edge
`timescale 1ns/100ps
module testbench;
	localparam int P = 20;
	localparam int F = 8;
	logic clk = 0, rst = 1, fr = 0, por = 0, uv = 0, ov = 0, uvt = 0, ovt = 0, iol = 0;
	logic req = 0, wr = 0, pull = 0, shorth = 0, line, oe, se, rc, dse, fm, spi, ff;
	logic [7:0] wd = 8'h00, rd;
	int n_fail = 0, comparisons = 0, cycles = 0;
	always #2 clk = ~clk;
	bridge_line_host host (.i_dev_oe(oe), .i_pull_low(pull), .i_short_high(shorth), .o_line(line));
	logic_supply_supervisor #(.POR_CYCLES(17'(P)), .OFF_FILTER_CYCLES(15'(F)), .ON_FILTER_CYCLES(15'(F))) dut (
		.i_ref_clk(clk), .i_reset(rst), .i_above_functional_reset_level(fr), .i_above_por_level(por),
		.i_below_uv_threshold(uv), .i_above_ov_threshold(ov), .i_below_uv_test_threshold(uvt),
		.i_above_ov_test_threshold(ovt), .i_io_supply_low(iol), .i_bridge_enable_line(line),
		.o_bridge_enable_line(), .o_bridge_enable_line_oe(oe), .i_stage_on_request(req), .o_stage_enable(se),
		.i_status_write(wr), .i_status_wdata(wd), .o_status_rdata(rd), .o_regs_clear(rc),
		.o_diag_store_enable(dse), .o_flag_diag_mode(fm), .o_spi_enable(spi), .o_supply_fault_flag(ff));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wrs(input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		wd <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic complete_run();
		if (n_fail == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			complete_run();
		end
	end
	task automatic t_power();
		fr <= 1;
		por <= 1;
		cyc(P - 2);
		@(negedge clk);
		chk(rc, 1);
		cyc(6);
		@(negedge clk);
		chk(rc, 0);
		chk(oe, 0);
		chk(rd, 8'h87);
	endtask
	task automatic t_uv();
		cyc(1);
		req <= 1;
		cyc(2);
		pull <= 1;
		@(negedge clk);
		chk(se, 0);
		cyc(1);
		pull <= 0;
		uv <= 1;
		cyc(F - 3);
		uv <= 0;
		cyc(3);
		@(negedge clk);
		chk(ff, 0);
		chk(se, 1);
		cyc(1);
		uv <= 1;
		shorth <= 1;
		cyc(F + 3);
		@(negedge clk);
		chk({ff, oe, se, dse}, 8'h0C);
		chk(rd, 8'h81);
		wrs(8'h88);
		cyc(2);
		@(negedge clk);
		chk(rd, 8'h89);
		cyc(1);
		uv <= 0;
		shorth <= 0;
		cyc(F + 3);
		@(negedge clk);
		chk(ff, 0);
		chk(oe, 0);
		chk(rd, 8'h8F);
	endtask
	task automatic t_ovl();
		cyc(1);
		ov <= 1;
		cyc(F + 3);
		ov <= 0;
		@(negedge clk);
		chk(ff, 1);
		cyc(F + 3);
		@(negedge clk);
		chk(ff, 1);
		chk(rd, 8'h8A);
		wrs(8'h80);
		cyc(3);
		@(negedge clk);
		chk(ff, 0);
		chk(rd, 8'h87);
		cyc(1);
		ov <= 1;
		cyc(F + 3);
		ov <= 0;
		cyc(F + 3);
		@(negedge clk);
		chk({ff, se}, 8'h01);
	endtask
	task automatic t_test();
		for (int i = 0; i < 2; i++) begin
			wrs(i ? 8'h40 : 8'h00);
			uvt <= (i == 1);
			ovt <= (i == 0);
			cyc(F + 4);
			@(negedge clk);
			chk(rd, i ? 8'h41 : 8'h02);
			cyc(1);
			uvt <= 0;
			ovt <= 0;
			wrs(8'h80);
			cyc(F + 4);
			@(negedge clk);
			chk(rd, 8'h87);
		end
	endtask
	task automatic t_flag();
		cyc(1);
		iol <= 1;
		wrs(8'h08);
		ov <= 1;
		@(negedge clk);
		chk(fm, 1);
		chk(spi, 0);
		chk(rd, 8'h00);
		cyc(F + 3);
		ov <= 0;
		@(negedge clk);
		chk(ff, 1);
		cyc(F + 3);
		@(negedge clk);
		chk(ff, 0);
		cyc(1);
		iol <= 0;
		cyc(2);
		@(negedge clk);
		chk(spi, 1);
		chk(rd, 8'h87);
	endtask
	task automatic t_por();
		wrs(8'h88);
		cyc(1);
		por <= 0;
		@(negedge clk);
		chk({oe, se}, 8'h02);
		cyc(3);
		@(negedge clk);
		chk(rc, 1);
		cyc(1);
		por <= 1;
		cyc(P + 4);
		@(negedge clk);
		chk(rd, 8'h87);
	endtask
	initial begin
		cyc(8);
		rst <= 0;
		t_power();
		t_uv();
		t_ovl();
		t_test();
		t_flag();
		t_por();
		complete_run();
	end
endmodule // testbench
